// [shared/crb_pkg.sv]
`default_nettype none
package crb_pkg;
	localparam int DATA_BYTES = 8;
	localparam int FIFO_DEPTH = 8;
	// Register offsets
	localparam logic [7:0] OFF_PIN_CTRL = 8'h0c;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h2b;
	localparam logic [7:0] OFF_INT_FLAG = 8'h2c;
	localparam logic [7:0] OFF_HIGH_PRIORITY_RX_BUFFER_CTRL = 8'h60;
	localparam logic [7:0] OFF_LOW_PRIORITY_RX_BUFFER_CTRL = 8'h70;
	localparam logic [2:0] RX_SPACE_HI = 3'h3;
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_SIDH = 4'h1;
	localparam logic [3:0] IDX_SIDL = 4'h2;
	localparam logic [3:0] IDX_EID8 = 4'h3;
	localparam logic [3:0] IDX_EID0 = 4'h4;
	localparam logic [3:0] IDX_DLC = 4'h5;
	localparam logic [3:0] IDX_DATA0 = 4'h6;
	localparam logic [3:0] IDX_LAST = 4'hd;
	// Field positions
	localparam int BIT_ROLLOVER = 2;
	localparam int BIT_PIN_FE = 2;
	localparam int BIT_PIN_ST = 4;
	// Writable masks
	localparam logic [7:0] WMASK_HIGH_PRIORITY_RX_BUFFER = 8'h64;
	localparam logic [7:0] WMASK_LOW_PRIORITY_RX_BUFFER = 8'h60;
	localparam logic [7:0] WMASK_PIN = 8'h3f;
	localparam logic [7:0] WMASK_INT = 8'h03;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		CRB_MODE_FILTER = 2'b00,
		CRB_MODE_RSV1 = 2'b01,
		CRB_MODE_RSV2 = 2'b10,
		CRB_MODE_ANY = 2'b11
	} crb_mode_t;

	typedef struct packed {
		logic [10:0] sid;
		logic srr;
		logic ide;
		logic [17:0] eid;
		logic rtr;
		logic [1:0] rsv;
		logic [3:0] dlc;
		logic [8*DATA_BYTES-1:0] data;
	} crb_frame_t;

	typedef struct packed {
		crb_frame_t frame;
		logic error;
		logic b0_match;
		logic b0_filter;
		logic b1_match;
		logic [2:0] b1_filter;
	} crb_entry_t;

	typedef struct packed {
		logic ide;
		logic [10:0] sid;
		logic [17:0] ext;
		logic ext_from_data;
	} crb_key_t;

	typedef struct packed {
		crb_frame_t frame;
		logic [2:0] hit;
	} crb_slot_t;
endpackage
`default_nettype wire

// [verification/crb_engine_model.sv]
`timescale 1ns/100ps
`default_nettype none
module crb_engine_model import crb_pkg::*; (
	input wire logic clk_in,
	input wire logic frame_ready_in,
	output logic frame_valid_out,
	output crb_frame_t frame_out,
	output logic error_out,
	output logic b0_hit_out,
	output logic b0_sel_out,
	output logic b1_hit_out,
	output logic [2:0] b1_sel_out
);
	initial begin
		frame_valid_out = 1'b0;
		frame_out = '0;
		error_out = 1'b0;
		b0_hit_out = 1'b0;
		b0_sel_out = 1'b0;
		b1_hit_out = 1'b0;
		b1_sel_out = 3'h0;
	end
	// Offer held until the taking edge; released frame lines show the inverse,
	// so a design that samples late never sees a clean copy
	task automatic send(input crb_frame_t f, input logic h0, input logic s0,
		input logic h1, input logic [2:0] s1, input logic e);
		@(negedge clk_in);
		frame_valid_out = 1'b1;
		frame_out = f;
		error_out = e;
		b0_hit_out = h0;
		b0_sel_out = s0;
		b1_hit_out = h1;
		b1_sel_out = s1;
		while (frame_ready_in !== 1'b1) @(negedge clk_in);
		@(posedge clk_in);
		@(negedge clk_in);
		frame_valid_out = 1'b0;
		frame_out = ~f;
		error_out = ~e;
	endtask
endmodule
`default_nettype wire

// [verification/crb_receive_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module crb_receive_bench import crb_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic rx_pin = 1'b1;
	logic idle = 1'b1;
	logic sp = 1'b0;
	logic sof_en = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wm = 8'hff;
	logic [7:0] wd = 8'h00;
	logic fv, fr, fe, m0, s0, m1, sof, int_n;
	logic [2:0] s1;
	logic [7:0] rdata;
	logic [1:0] pin_n, oe_n;
	crb_frame_t fd;
	crb_key_t key;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	crb_receive crb_receive_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.frame_valid_in(fv), .frame_ready_out(fr), .frame_in(fd), .frame_error_in(fe),
		.filter_key_out(key), .b0_match_in(m0), .b0_match_filter_in(s0),
		.b1_match_in(m1), .b1_match_filter_in(s1), .bus_receive_pin_in(rx_pin),
		.bus_idle_in(idle), .sample_point_in(sp), .sof_enable_in(sof_en), .sof_out(sof),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_wmask_in(wm), .reg_wdata_in(wd),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .int_n_out(int_n),
		.buffer_full_pin_n_out(pin_n), .buffer_full_pin_oe_n_out(oe_n));

	crb_engine_model crb_engine_model_inst (.clk_in(clk_in), .frame_ready_in(fr),
		.frame_valid_out(fv), .frame_out(fd), .error_out(fe), .b0_hit_out(m0),
		.b0_sel_out(s0), .b1_hit_out(m1), .b1_sel_out(s1));

	initial forever #2 clk_in = ~clk_in;

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Run is a few hundred cycles; the ceiling only catches a hang
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			$display("ERROR t=%0t timeout", $time);
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		comparisons++;
		if (act !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h want %h", $time, act, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(negedge clk_in);
		addr = a;
		wd = d;
		wm = m;
		wr = 1'b1;
		@(negedge clk_in);
		wr = 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_in);
		addr = a;
		rd = 1'b1;
		@(negedge clk_in);
		rd = 1'b0;
		chk(rdata, exp);
	endtask

	function automatic crb_frame_t mk(input logic [10:0] id, input logic [63:0] d,
		input logic r);
		mk = '0;
		mk.sid = id;
		mk.ide = 1'b1;
		mk.srr = r;
		mk.rtr = r;
		mk.dlc = 4'h8;
		mk.data = d;
	endfunction

	task automatic t_regs();
		rreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00);
		rreg(OFF_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h00);
		chk({6'h0, oe_n}, 8'h03);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'hff, 8'hff);
		rreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h66);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00, 8'hff);
		rreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00);
		rreg(8'h20, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_load();
		wreg(OFF_INT_ENABLE, 8'h03, 8'hff);
		crb_engine_model_inst.send(mk(11'h5a5, 64'h8877665544332211, 1'b1), 1, 1, 1, 3'h2, 0);
		wait_n(4);
		chk({7'h0, int_n}, 8'h00);
		rreg(OFF_INT_FLAG, 8'h01);
		rreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h09);
		rreg(8'h61, 8'hb4);
		rreg(8'h66, 8'h11);
		rreg(8'h6d, 8'h88);
		// Buffer still full and rollover off, so this frame must vanish
		crb_engine_model_inst.send(mk(11'h123, 64'h99, 1'b0), 1, 0, 0, 3'h0, 0);
		wait_n(4);
		rreg(8'h66, 8'h11);
		rreg(OFF_INT_FLAG, 8'h01);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h04, 8'hff);
		crb_engine_model_inst.send(mk(11'h0f0, 64'hab, 1'b0), 1, 0, 0, 3'h4, 0);
		wait_n(4);
		rreg(OFF_INT_FLAG, 8'h03);
		rreg(OFF_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h00);
		rreg(8'h76, 8'hab);
		rreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h0f);
		wreg(OFF_INT_FLAG, 8'h00, 8'hff);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00, 8'hff);
		wait_n(3);
		chk({7'h0, int_n}, 8'h01);
		crb_engine_model_inst.send(mk(11'h044, 64'hcd, 1'b0), 0, 0, 1, 3'h5, 0);
		wait_n(4);
		rreg(OFF_INT_FLAG, 8'h02);
		rreg(OFF_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h05);
		wreg(OFF_INT_FLAG, 8'h00, 8'hff);
		$display("test load done");
	endtask

	task automatic t_mode();
		crb_frame_t f;
		f = mk(11'h011, 64'h1177, 1'b0);
		f.ide = 1'b0;
		// Key is looked at while the offered standard frame still stands
		fork
			crb_engine_model_inst.send(f, 0, 0, 0, 3'h2, 0);
			begin
				@(negedge clk_in);
				@(posedge clk_in);
				chk(key.ext[15:8], 8'h77);
				chk(key.ext[7:0], 8'h11);
				chk({7'h0, key.ext_from_data}, 8'h01);
			end
		join
		wait_n(4);
		rreg(OFF_INT_FLAG, 8'h00);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h60, 8'hff);
		crb_engine_model_inst.send(mk(11'h022, 64'h5c, 1'b0), 0, 0, 0, 3'h2, 1);
		wait_n(4);
		rreg(OFF_INT_FLAG, 8'h01);
		rreg(8'h66, 8'h5c);
		wreg(OFF_INT_FLAG, 8'h00, 8'hff);
		wreg(OFF_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00, 8'hff);
		$display("test mode done");
	endtask

	task automatic t_pins();
		wreg(OFF_PIN_CTRL, 8'h33, 8'hff);
		wait_n(2);
		chk({6'h0, oe_n}, 8'h03);
		wreg(OFF_PIN_CTRL, 8'h0f, 8'hff);
		crb_engine_model_inst.send(mk(11'h055, 64'h1, 1'b0), 1, 0, 0, 3'h2, 0);
		wait_n(4);
		chk({4'h0, oe_n, pin_n}, 8'h02);
		wreg(OFF_INT_FLAG, 8'h00, 8'hff);
		wait_n(2);
		chk({4'h0, oe_n, pin_n}, 8'h03);
		wreg(OFF_PIN_CTRL, 8'h0c, 8'hff);
		wreg(OFF_PIN_CTRL, 8'h20, 8'h20);
		wait_n(2);
		chk({4'h0, oe_n, pin_n}, 8'h02);
		rreg(OFF_PIN_CTRL, 8'h2c);
		wreg(OFF_PIN_CTRL, 8'h00, 8'hff);
		$display("test pins done");
	endtask

	// Count start pulses around one sample point; back is the level before it
	task automatic sof_try(input logic back, input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		@(negedge clk_in);
		sof_en = 1'b1;
		rx_pin = 1'b0;
		wait_n(5);
		rx_pin = back;
		wait_n(4);
		sp = 1'b1;
		@(negedge clk_in);
		sp = 1'b0;
		repeat (3) begin
			if (sof === 1'b1) n++;
			@(negedge clk_in);
		end
		rx_pin = 1'b1;
		wait_n(6);
		chk(n, exp);
	endtask

	task automatic t_sof();
		sof_try(1'b0, 8'h01);
		sof_try(1'b1, 8'h00);
		$display("test sof done");
	endtask

	task automatic t_fifo();
		@(negedge clk_in);
		addr = OFF_HIGH_PRIORITY_RX_BUFFER_CTRL;
		rd = 1'b1;
		repeat (FIFO_DEPTH) crb_engine_model_inst.send(mk(11'h033, 64'h0, 1'b0), 0, 0, 0, 3'h2, 0);
		chk({7'h0, fr}, 8'h00);
		rd = 1'b0;
		wait_n(12);
		chk({7'h0, fr}, 8'h01);
		$display("test fifo done");
	endtask

	initial begin
		wait_n(16);
		rst_n_in = 1'b1;
		t_regs();
		t_load();
		t_mode();
		t_pins();
		t_sof();
		t_fifo();
		report_and_stop();
	end
endmodule
`default_nettype wire

// [verilog/crb_receive.sv]
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Assembly path captures next bus frame while its queue has room
// - Accepted frame overwrites whole receive buffer
// - Loading a buffer sets its complete flag
// - Set flag blocks loads; host clears it
// - Enabled set flag drives interrupt low
// - Buffer 0 filters checked before buffer 1
// - Rollover sends buffer 0 overflow to buffer 1
// - Buffer 0 bit 0 names accepting filter
// - Buffer 1 three-bit hit code, rollover 000/001
// - Control bit 3 shows remote request
// - Mode 00 accepts only filter-passing valid frames
// - Buffer 0 standard frames compare first data bytes
// - Mode 11 accepts every frame
// - Mode 11 loads partial error frames
// - Idle-bus falling edge held to sample gives pulse
// - Short dominant glitch gives no pulse
// - Pin function disabled puts pin high impedance
// - Interrupt mode pin is inverted complete flag
// - Digital output mode drives state bit
// - Buffer 0 bit 1 mirrors rollover enable

module crb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic push, pop;

	assign in_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out = mem[rd_ptr[AW-1:0]];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage has no reset; only pointers say what is valid
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_in;
		end
	end
endmodule

module crb_receive import crb_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Protocol engine side
	input wire logic frame_valid_in,
	output logic frame_ready_out,
	input wire crb_frame_t frame_in,
	input wire logic frame_error_in,
	output crb_key_t filter_key_out,
	input wire logic b0_match_in,
	input wire logic b0_match_filter_in,
	input wire logic b1_match_in,
	input wire logic [2:0] b1_match_filter_in,
	input wire logic bus_receive_pin_in,
	input wire logic bus_idle_in,
	input wire logic sample_point_in,
	input wire logic sof_enable_in,
	output logic sof_out,
	// Host register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wmask_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic int_n_out,
	output logic [1:0] buffer_full_pin_n_out,
	output logic [1:0] buffer_full_pin_oe_n_out
);
	crb_entry_t in_entry, head;
	logic head_valid, pop;
	crb_slot_t slot [2];
	crb_slot_t next_slot [2];
	logic [1:0] mode [2];
	logic [1:0] next_mode [2];
	logic rollover_enable, next_rollover_enable;
	logic [5:0] full_pin_control, next_full_pin_control;
	logic [1:0] rx_interrupt_enable, next_rx_interrupt_enable;
	logic [1:0] rx_complete_flag, next_rx_complete_flag;
	logic [7:0] next_reg_rdata;
	logic next_int_n;
	logic [1:0] next_pin_n, next_pin_oe_n;
	logic ok0, ok1, load0, load1, rx_space_read;
	logic [7:0] new_b0, new_b1, new_pin, new_ie, new_if;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction

	function automatic logic [7:0] bit_modify(input logic [7:0] old, input logic [7:0] mask,
			input logic [7:0] data, input logic [7:0] wmask);
		return (old & ~(mask & wmask)) | (data & mask & wmask);
	endfunction

	function automatic logic accepts(input logic [1:0] m, input logic err, input logic hit);
		return (m == CRB_MODE_ANY) || (m == CRB_MODE_FILTER && !err && hit);
	endfunction

	function automatic logic [7:0] slot_byte(input crb_slot_t s, input logic [3:0] idx);
		logic [3:0] d;
		d = idx - IDX_DATA0;
		unique case (idx)
			IDX_SIDH: slot_byte = s.frame.sid[10:3];
			IDX_SIDL: slot_byte = {s.frame.sid[2:0], s.frame.srr, s.frame.ide, 1'b0,
				s.frame.eid[17:16]};
			IDX_EID8: slot_byte = s.frame.eid[15:8];
			IDX_EID0: slot_byte = s.frame.eid[7:0];
			IDX_DLC: slot_byte = {1'b0, s.frame.rtr, s.frame.rsv, s.frame.dlc};
			default: slot_byte = (idx >= IDX_DATA0 && idx <= IDX_LAST) ?
				s.frame.data[d[2:0]*8 +: 8] : RESET_BYTE;
		endcase
	endfunction

	function automatic logic remote_of(input crb_slot_t s);
		return s.frame.ide ? s.frame.rtr : s.frame.srr;
	endfunction

	// Standard frames expose data bytes 0 and 1 to buffer 0 extended filter bits
	always_comb begin
		filter_key_out.ide = frame_in.ide;
		filter_key_out.sid = frame_in.sid;
		filter_key_out.ext_from_data = !frame_in.ide && mode[0] == CRB_MODE_FILTER;
		filter_key_out.ext = frame_in.ide ? frame_in.eid :
			{2'b00, frame_in.data[7:0], frame_in.data[15:8]};
		in_entry.frame = frame_in;
		in_entry.error = frame_error_in;
		in_entry.b0_match = b0_match_in;
		in_entry.b0_filter = b0_match_filter_in;
		in_entry.b1_match = b1_match_in;
		in_entry.b1_filter = b1_match_filter_in;
	end

	// Engine hands every frame to the assembly queue; ready stalls it when full
	crb_fifo #(.WIDTH($bits(crb_entry_t)), .DEPTH(FIFO_DEPTH)) u_assembly_buffer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(frame_valid_in),
		.in_ready_out(frame_ready_out),
		.in_data_in(in_entry),
		.out_valid_out(head_valid),
		.out_ready_in(!rx_space_read),
		.out_data_out(head)
	);

	// Hold commits while the host reads a buffer so it never sees a torn frame
	assign rx_space_read = reg_rd_in && reg_addr_in[7:5] == RX_SPACE_HI;
	assign pop = head_valid && !rx_space_read;
	assign ok0 = accepts(mode[0], head.error, head.b0_match);
	assign ok1 = accepts(mode[1], head.error, head.b1_match);
	assign load0 = pop && ok0 && !rx_complete_flag[0];
	assign load1 = pop && !rx_complete_flag[1] && ((ok0 && rx_complete_flag[0] &&
		rollover_enable) || (!ok0 && ok1));

	// Bit-modify merge of each host write; read-only bits are masked off
	assign new_b0 = bit_modify({1'b0, mode[0], 2'b00, rollover_enable, 2'b00},
		reg_wmask_in, reg_wdata_in, WMASK_HIGH_PRIORITY_RX_BUFFER);
	assign new_b1 = bit_modify({1'b0, mode[1], 5'h00}, reg_wmask_in, reg_wdata_in,
		WMASK_LOW_PRIORITY_RX_BUFFER);
	assign new_pin = bit_modify({2'b00, full_pin_control}, reg_wmask_in, reg_wdata_in,
		WMASK_PIN);
	assign new_ie = bit_modify({6'h00, rx_interrupt_enable}, reg_wmask_in, reg_wdata_in,
		WMASK_INT);
	assign new_if = bit_modify({6'h00, rx_complete_flag}, reg_wmask_in, reg_wdata_in,
		WMASK_INT);

	always_comb begin
		next_slot[0] = slot[0];
		next_slot[1] = slot[1];
		next_mode[0] = mode[0];
		next_mode[1] = mode[1];
		next_rollover_enable = rollover_enable;
		next_full_pin_control = full_pin_control;
		next_rx_interrupt_enable = rx_interrupt_enable;
		next_rx_complete_flag = rx_complete_flag;
		next_reg_rdata = reg_rdata_out;
		if (reg_wr_in) begin
			if (reg_hit(reg_addr_in, OFF_HIGH_PRIORITY_RX_BUFFER_CTRL)) begin
				next_mode[0] = new_b0[6:5];
				next_rollover_enable = new_b0[BIT_ROLLOVER];
			end
			if (reg_hit(reg_addr_in, OFF_LOW_PRIORITY_RX_BUFFER_CTRL)) begin
				next_mode[1] = new_b1[6:5];
			end
			if (reg_hit(reg_addr_in, OFF_PIN_CTRL)) begin
				next_full_pin_control = new_pin[5:0];
			end
			if (reg_hit(reg_addr_in, OFF_INT_ENABLE)) begin
				next_rx_interrupt_enable = new_ie[1:0];
			end
			if (reg_hit(reg_addr_in, OFF_INT_FLAG)) begin
				next_rx_complete_flag = new_if[1:0];
			end
		end
		// Loads come after host writes so a set wins over a same-cycle clear
		if (load0) begin
			next_slot[0].frame = head.frame;
			next_slot[0].hit = {2'b00, head.b0_filter};
			next_rx_complete_flag[0] = 1'b1;
		end
		if (load1) begin
			next_slot[1].frame = head.frame;
			next_slot[1].hit = ok0 ? {2'b00, head.b0_filter} : head.b1_filter;
			next_rx_complete_flag[1] = 1'b1;
		end
		if (reg_rd_in) begin
			if (reg_hit(reg_addr_in, OFF_HIGH_PRIORITY_RX_BUFFER_CTRL)) begin
				next_reg_rdata = {1'b0, mode[0], 1'b0, remote_of(slot[0]), rollover_enable,
					rollover_enable, slot[0].hit[0]};
			end else if (reg_hit(reg_addr_in, OFF_LOW_PRIORITY_RX_BUFFER_CTRL)) begin
				next_reg_rdata = {1'b0, mode[1], 1'b0, remote_of(slot[1]), slot[1].hit};
			end else if (rx_space_read) begin
				next_reg_rdata = slot_byte(slot[reg_addr_in[4]], reg_addr_in[3:0]);
			end else if (reg_hit(reg_addr_in, OFF_PIN_CTRL)) begin
				next_reg_rdata = {2'b00, full_pin_control[5:4] & ~full_pin_control[1:0],
					full_pin_control[3:0]};
			end else if (reg_hit(reg_addr_in, OFF_INT_ENABLE)) begin
				next_reg_rdata = {6'h0, rx_interrupt_enable};
			end else if (reg_hit(reg_addr_in, OFF_INT_FLAG)) begin
				next_reg_rdata = {6'h0, rx_complete_flag};
			end else begin
				next_reg_rdata = RESET_BYTE;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode[0] <= CRB_MODE_FILTER;
			mode[1] <= CRB_MODE_FILTER;
			rollover_enable <= 1'b0;
			full_pin_control <= '0;
			rx_interrupt_enable <= '0;
			rx_complete_flag <= '0;
			reg_rdata_out <= RESET_BYTE;
		end else begin
			mode[0] <= next_mode[0];
			mode[1] <= next_mode[1];
			rollover_enable <= next_rollover_enable;
			full_pin_control <= next_full_pin_control;
			rx_interrupt_enable <= next_rx_interrupt_enable;
			rx_complete_flag <= next_rx_complete_flag;
			reg_rdata_out <= next_reg_rdata;
		end
	end

	// Cleared at reset so the control status bits read 0 before any frame
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot[0] <= '0;
			slot[1] <= '0;
		end else begin
			slot[0] <= next_slot[0];
			slot[1] <= next_slot[1];
		end
	end

	// Interrupt and buffer-full pins
	generate
		for (genvar i = 0; i < 2; i++) begin : g_pin
			always_comb begin
				next_pin_oe_n[i] = !full_pin_control[BIT_PIN_FE+i];
				next_pin_n[i] = full_pin_control[i] ? !next_rx_complete_flag[i] :
					full_pin_control[BIT_PIN_ST+i];
			end
		end
	endgenerate

	assign next_int_n = !(|(next_rx_complete_flag & rx_interrupt_enable));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			int_n_out <= 1'b1;
			buffer_full_pin_n_out <= 2'b11;
			buffer_full_pin_oe_n_out <= 2'b11;
		end else begin
			int_n_out <= next_int_n;
			buffer_full_pin_n_out <= next_pin_n;
			buffer_full_pin_oe_n_out <= next_pin_oe_n;
		end
	end

	// Start-of-frame detection
	typedef enum logic [0:0] {
		CRB_SOF_WATCH = 1'b0,
		CRB_SOF_ARMED = 1'b1
	} crb_sof_state_t;
	crb_sof_state_t sof_state, next_sof_state;
	logic rx_meta, rx_sync, rx_prev, next_sof;

	always_comb begin
		next_sof_state = sof_state;
		next_sof = 1'b0;
		unique case (sof_state)
			CRB_SOF_WATCH: begin
				if (sof_enable_in && bus_idle_in && rx_prev && !rx_sync) begin
					next_sof_state = CRB_SOF_ARMED;
				end
			end
			CRB_SOF_ARMED: begin
				if (rx_sync) begin
					next_sof_state = CRB_SOF_WATCH;
				end else if (sample_point_in) begin
					next_sof = 1'b1;
					next_sof_state = CRB_SOF_WATCH;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
			sof_state <= CRB_SOF_WATCH;
			sof_out <= 1'b0;
		end else begin
			rx_meta <= bus_receive_pin_in;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
			sof_state <= next_sof_state;
			sof_out <= next_sof;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_load_sets_flag: assert property (load0 |=> rx_complete_flag[0])
		else $error("buffer 0 load did not set its flag");
	a_full_blocks_load: assert property (rx_complete_flag[1] |-> !load1)
		else $error("load into full buffer 1");
	a_int_follows_flag: assert property (rx_complete_flag[0] &&
		$past(rx_interrupt_enable[0]) |-> !int_n_out)
		else $error("interrupt not asserted for enabled flag");
	a_b0_first: assert property ((pop && ok0 && !rx_complete_flag[0]) |-> load0 && !load1)
		else $error("buffer 0 not given priority");
	a_rollover_route: assert property (pop && ok0 && rx_complete_flag[0] &&
		rollover_enable && !rx_complete_flag[1] |=> rx_complete_flag[1] &&
		slot[1].hit[2:1] == 2'b00)
		else $error("rollover frame not moved to buffer 1");
	a_discard_full: assert property (pop && ok0 && rx_complete_flag[0] &&
		!rollover_enable |=> $stable(slot[0].frame))
		else $error("full buffer 0 overwritten");
	a_mode_any_load: assert property (pop && mode[0] == CRB_MODE_ANY &&
		!rx_complete_flag[0] |-> load0)
		else $error("mode 11 frame not loaded");
	a_mirror_read: assert property (reg_rd_in && reg_addr_in == OFF_HIGH_PRIORITY_RX_BUFFER_CTRL |=>
		reg_rdata_out[1] == $past(rollover_enable))
		else $error("rollover mirror mismatch");
	a_pin_disabled: assert property (!full_pin_control[BIT_PIN_FE] |=>
		buffer_full_pin_oe_n_out[0])
		else $error("disabled pin driven");
	a_pin_irq_mode: assert property (full_pin_control[BIT_PIN_FE] &&
		full_pin_control[0] |=> buffer_full_pin_n_out[0] == !rx_complete_flag[0])
		else $error("pin does not mirror flag");
	a_sof_glitch: assert property ((sof_state == CRB_SOF_ARMED && rx_sync) |=> !sof_out)
		else $error("pulse on glitch");
	c_rollover: cover property (load1 && ok0);
	c_sof_pulse: cover property (sof_out);
	c_both_full: cover property (rx_complete_flag == 2'b11 && head_valid);
endmodule
`default_nettype wire
